// ===== design/chmu_pkg.sv
/*
 Package for the cross-halfword multiply-accumulate unit: register
 offsets, field positions, reset values, variant and state encodings.
 Assumes a 32-bit register bus with byte addresses.
*/
package chmu_pkg;

   // ----------------------------------------------------------------
   // Widths and carriers
   // ----------------------------------------------------------------
   typedef logic [31:0] chmu_word_t;
   typedef logic [7:0]  chmu_addr_t;
   typedef logic [3:0]  chmu_be_t;
   typedef logic [3:0]  chmu_cr_t;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam chmu_addr_t OFS_SRC_A = 8'h00;
   localparam chmu_addr_t OFS_SRC_B = 8'h04;
   localparam chmu_addr_t OFS_ACC   = 8'h08;
   localparam chmu_addr_t OFS_CTRL  = 8'h0C;
   localparam chmu_addr_t OFS_FPEX  = 8'h10;
   localparam chmu_addr_t OFS_CFZ   = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   // Bit 0 of the architectural word is our bit 31
   localparam int HALF_LO_MSB   = 15;
   localparam int HALF_HI_LSB   = 16;
   localparam int WORD_MSB      = 31;
   localparam int CTRL_FLD_MSB  = 3;
   localparam int CTRL_GO_BIT   = 4;
   localparam int CTRL_BUSY_BIT = 8;
   localparam int FPEX_SO_BIT   = 31;
   localparam int FPEX_OVF_BIT  = 30;
   localparam int CR_NEG_BIT    = 3;
   localparam int CR_POS_BIT    = 2;
   localparam int CR_ZERO_BIT   = 1;
   localparam int CR_SO_BIT     = 0;

   // ----------------------------------------------------------------
   // Values
   // ----------------------------------------------------------------
   localparam chmu_word_t RST_WORD  = 32'h0000_0000;
   localparam chmu_cr_t   RST_CR    = 4'h0;
   localparam chmu_word_t SAT_S_MAX = 32'h7FFF_FFFF;
   localparam chmu_word_t SAT_S_MIN = 32'h8000_0000;
   localparam chmu_word_t SAT_U_MAX = 32'hFFFF_FFFF;

   // ----------------------------------------------------------------
   // Variants, control and states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      VAR_MOD_S = 2'h0,
      VAR_SAT_S = 2'h1,
      VAR_SAT_U = 2'h2,
      VAR_MOD_U = 2'h3
   } chmu_variant_t;

   typedef struct packed {
      logic          ovf_en;
      logic          record;
      chmu_variant_t variant;
   } chmu_ctrl_t;

   localparam chmu_ctrl_t RST_CTRL = 4'h0;

   typedef struct packed {
      chmu_word_t result;
      logic       ovf;
   } chmu_mac_out_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CALC = 2'b10
   } chmu_state_t;

endpackage

// ===== design/chmu_mac.sv
/*
 Combinational cross-halfword multiply-accumulate datapath.
 Assumes operands are held stable by the caller for the cycle in use.
*/
`timescale 1ns/100ps
`default_nettype none

module chmu_mac (
   // Operands
   input  wire chmu_pkg::chmu_word_t    src_a_i,
   input  wire chmu_pkg::chmu_word_t    src_b_i,
   input  wire chmu_pkg::chmu_word_t    acc_i,
   input  wire chmu_pkg::chmu_variant_t variant_i,
   // Result
   output var  chmu_pkg::chmu_mac_out_t mac_o
);
   import chmu_pkg::*;

   logic signed [15:0] half_a;
   logic signed [15:0] half_b;
   logic signed [31:0] sprod;
   logic        [31:0] uprod;
   logic        [31:0] prod;
   logic        [32:0] sum;
   logic               is_signed;

   always_comb begin
      half_a    = src_a_i[HALF_LO_MSB:0];          // RULE_01 RULE_17
      half_b    = src_b_i[WORD_MSB:HALF_HI_LSB];   // RULE_01 RULE_17
      sprod     = half_a * half_b;
      uprod     = src_a_i[HALF_LO_MSB:0] * src_b_i[WORD_MSB:HALF_HI_LSB];
      is_signed = (variant_i == VAR_MOD_S) || (variant_i == VAR_SAT_S);
      prod      = is_signed ? sprod : uprod;        // RULE_05 RULE_06 RULE_07
      if (is_signed) begin
         sum       = {acc_i[WORD_MSB], acc_i} + {prod[WORD_MSB], prod}; // RULE_02
         mac_o.ovf = sum[32] ^ sum[WORD_MSB];      // RULE_18
      end else begin
         sum       = {1'b0, acc_i} + {1'b0, prod}; // RULE_02 RULE_08
         mac_o.ovf = sum[32];                      // RULE_18
      end
      unique case (variant_i)
         VAR_MOD_S,
         VAR_MOD_U: begin
            mac_o.result = sum[WORD_MSB:0];        // RULE_03 RULE_13
         end
         VAR_SAT_S: begin
            if (!mac_o.ovf) begin
               mac_o.result = sum[WORD_MSB:0];     // RULE_03
            end else if (sum[32]) begin
               mac_o.result = SAT_S_MIN;           // RULE_04 RULE_15
            end else begin
               mac_o.result = SAT_S_MAX;           // RULE_04 RULE_14
            end
         end
         VAR_SAT_U: begin
            mac_o.result = mac_o.ovf ? SAT_U_MAX : sum[WORD_MSB:0]; // RULE_16
         end
      endcase
   end

endmodule // chmu_mac

`default_nettype wire

// ===== design/chmu_top.sv
/*
 Top of the cross-halfword multiply-accumulate unit with its register
 file on an Avalon-MM slave port with waitrequest.
 Assumes a master that holds each request until waitrequest is low.
*/
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RULE_01: Multiply low halfword of first source by high halfword of second.
// RULE_02: Add the 32-bit product to the accumulator as a 33-bit sum.
// RULE_03: Without saturation, write the low 32 bits of the sum.
// RULE_04: Saturating variants write nearest representable value on overflow.
// RULE_05: Modulo signed: signed operands, low 32 bits, never saturated.
// RULE_06: Saturate signed: signed product, clamp on signed overflow.
// RULE_07: Saturate unsigned: unsigned product, clamp on unsigned overflow.
// RULE_08: Modulo unsigned: unsigned product, low 32 bits, never saturated.
// RULE_09: Plain form leaves exception flags and condition field untouched.
// RULE_10: Record form updates condition field only, not overflow or sticky.
// RULE_11: Overflow form updates overflow and sticky, not condition field.
// RULE_12: Combined form updates overflow, sticky and condition field.
// RULE_13: Modulo variants drop the top bit of the 33-bit sum.
// RULE_14: Signed sum above maximum positive clamps to 0x7FFF_FFFF.
// RULE_15: Signed sum below most negative clamps to 0x8000_0000.
// RULE_16: Unsigned sum above all ones clamps to 0xFFFF_FFFF.
// RULE_17: Bit 0 is the MSB, so bits 16 to 31 are the low half.
// RULE_18: Overflow flag follows sum overflow; sticky flag only ever sets.
// RULE_19: Condition field holds negative, positive, zero and sticky copy.
module chmu_top (
   // Clock and reset
   input  wire logic                core_clk_i,
   input  wire logic                rst_i,
   // Avalon-MM slave
   input  wire chmu_pkg::chmu_addr_t avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire chmu_pkg::chmu_word_t avs_writedata_i,
   input  wire chmu_pkg::chmu_be_t   avs_byteenable_i,
   output var  chmu_pkg::chmu_word_t avs_readdata_o,
   output logic                     avs_waitrequest_o
);
   import chmu_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   chmu_state_t   state;
   chmu_state_t   next_state;
   chmu_word_t    src_a;
   chmu_word_t    next_src_a;
   chmu_word_t    src_b;
   chmu_word_t    next_src_b;
   chmu_word_t    acc;
   chmu_word_t    next_acc;
   chmu_ctrl_t    ctrl;
   chmu_ctrl_t    next_ctrl;
   logic          ovf;
   logic          next_ovf;
   logic          so;
   logic          next_so;
   chmu_cr_t      cfz;
   chmu_cr_t      next_cfz;
   logic          next_wait;
   chmu_word_t    next_rdata;
   chmu_mac_out_t mac;
   chmu_word_t    wr_val;
   chmu_word_t    rd_val;
   logic          wr_done;
   logic          sum_so;

   function automatic chmu_word_t be_merge(input chmu_word_t old_v,
                                           input chmu_word_t new_v,
                                           input chmu_be_t   be);
      chmu_word_t r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------
   chmu_mac u_mac (
      .src_a_i   (src_a),
      .src_b_i   (src_b),
      .acc_i     (acc),
      .variant_i (ctrl.variant),
      .mac_o     (mac)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_src_a = src_a;
      next_src_b = src_b;
      next_acc   = acc;
      next_ctrl  = ctrl;
      next_ovf   = ovf;
      next_so    = so;
      next_cfz   = cfz;
      next_wait  = avs_waitrequest_o;
      next_rdata = avs_readdata_o;
      wr_val     = RST_WORD;
      rd_val     = RST_WORD;
      sum_so     = so;
      wr_done    = avs_write_i && !avs_waitrequest_o;

      // Read mux; unmapped offsets read zero
      unique case (avs_address_i)
         OFS_SRC_A: rd_val = src_a;
         OFS_SRC_B: rd_val = src_b;
         OFS_ACC:   rd_val = acc;
         OFS_CTRL: begin
            rd_val[CTRL_FLD_MSB:0] = ctrl;
            rd_val[CTRL_BUSY_BIT]  = (state == ST_CALC);
         end
         OFS_FPEX: begin
            rd_val[FPEX_SO_BIT]  = so;
            rd_val[FPEX_OVF_BIT] = ovf;
         end
         OFS_CFZ:   rd_val[CTRL_FLD_MSB:0] = cfz;
         default:   rd_val = RST_WORD;
      endcase

      // Answer one cycle after the request, never while computing
      if (avs_waitrequest_o) begin
         if ((avs_read_i || avs_write_i) && state == ST_IDLE) begin
            next_wait  = 1'b0;
            next_rdata = rd_val;
         end
      end else begin
         next_wait = 1'b1;
      end

      // Writes take effect at the edge that completes the transfer
      if (wr_done) begin
         unique case (avs_address_i)
            OFS_SRC_A: next_src_a = be_merge(src_a, avs_writedata_i,
                                             avs_byteenable_i);
            OFS_SRC_B: next_src_b = be_merge(src_b, avs_writedata_i,
                                             avs_byteenable_i);
            OFS_ACC:   next_acc   = be_merge(acc, avs_writedata_i,
                                             avs_byteenable_i);
            OFS_CTRL: begin
               wr_val    = be_merge({28'h0, ctrl}, avs_writedata_i,
                                    avs_byteenable_i);
               next_ctrl = wr_val[CTRL_FLD_MSB:0];
               if (wr_val[CTRL_GO_BIT]) begin
                  next_state = ST_CALC;
               end
            end
            OFS_FPEX: begin
               wr_val   = be_merge(rd_val, avs_writedata_i,
                                   avs_byteenable_i);
               next_so  = wr_val[FPEX_SO_BIT];
               next_ovf = wr_val[FPEX_OVF_BIT];
            end
            OFS_CFZ: begin
               wr_val   = be_merge({28'h0, cfz}, avs_writedata_i,
                                   avs_byteenable_i);
               next_cfz = wr_val[CTRL_FLD_MSB:0];
            end
            default: wr_val = RST_WORD;
         endcase
      end

      // One-cycle execution of the selected form
      unique case (state)
         ST_IDLE: begin
         end
         ST_CALC: begin
            next_state = ST_IDLE;
            next_acc   = mac.result;                 // RULE_03 RULE_04
            if (ctrl.ovf_en) begin
               next_ovf = mac.ovf;                   // RULE_11 RULE_18
               sum_so  = so | mac.ovf;               // RULE_18
               next_so = sum_so;                     // RULE_11 RULE_12
            end
            if (ctrl.record) begin
               next_cfz[CR_NEG_BIT]  = mac.result[WORD_MSB];   // RULE_19
               next_cfz[CR_POS_BIT]  = !mac.result[WORD_MSB] &&
                                       (mac.result != RST_WORD);
               next_cfz[CR_ZERO_BIT] = (mac.result == RST_WORD); // RULE_19
               next_cfz[CR_SO_BIT]   = sum_so;       // RULE_10 RULE_12
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state             <= ST_IDLE;
         src_a             <= RST_WORD;
         src_b             <= RST_WORD;
         acc               <= RST_WORD;
         ctrl              <= RST_CTRL;
         ovf               <= 1'b0;
         so                <= 1'b0;
         cfz               <= RST_CR;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= RST_WORD;
      end else begin
         state             <= next_state;
         src_a             <= next_src_a;
         src_b             <= next_src_b;
         acc               <= next_acc;
         ctrl              <= next_ctrl;
         ovf               <= next_ovf;         // RULE_09
         so                <= next_so;
         cfz               <= next_cfz;         // RULE_09
         avs_waitrequest_o <= next_wait;
         avs_readdata_o    <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic signed [15:0] chk_ha;
   logic signed [15:0] chk_hb;
   logic signed [31:0] chk_sprod;
   logic        [31:0] chk_uprod;
   logic        [31:0] chk_ssum;
   logic        [32:0] chk_usum;
   logic               chk_calc;

   always_comb begin
      chk_ha    = src_a[15:0];
      chk_hb    = src_b[31:16];
      chk_sprod = chk_ha * chk_hb;
      chk_uprod = src_a[15:0] * src_b[31:16];
      chk_ssum  = acc + chk_sprod;
      chk_usum  = {1'b0, acc} + {1'b0, chk_uprod};
      chk_calc  = (state == ST_CALC);
   end

   default clocking chk_cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   chk_mod_signed: assert property ( // RULE_05
      chk_calc && ctrl.variant == VAR_MOD_S |=> acc == $past(chk_ssum))
      else $error("modulo signed result wrong");

   chk_mod_unsigned: assert property ( // RULE_08
      chk_calc && ctrl.variant == VAR_MOD_U
      |=> acc == $past(chk_usum[31:0]))
      else $error("modulo unsigned result wrong");

   chk_sat_pos: assert property ( // RULE_14
      chk_calc && ctrl.variant == VAR_SAT_S && !acc[31] && !chk_sprod[31]
      && chk_ssum[31] |=> acc == 32'h7FFF_FFFF)
      else $error("signed positive clamp wrong");

   chk_sat_neg: assert property ( // RULE_15
      chk_calc && ctrl.variant == VAR_SAT_S && acc[31] && chk_sprod[31]
      && !chk_ssum[31] |=> acc == 32'h8000_0000)
      else $error("signed negative clamp wrong");

   chk_sat_uns: assert property ( // RULE_16
      chk_calc && ctrl.variant == VAR_SAT_U && chk_usum[32]
      |=> acc == 32'hFFFF_FFFF)
      else $error("unsigned clamp wrong");

   chk_plain_flags: assert property ( // RULE_09
      chk_calc && !ctrl.record && !ctrl.ovf_en
      |=> $stable(cfz) && $stable(ovf) && $stable(so))
      else $error("plain form changed flags");

   chk_record_only: assert property ( // RULE_10
      chk_calc && ctrl.record && !ctrl.ovf_en
      |=> $stable(ovf) && $stable(so) && cfz[3] == acc[31]
          && cfz[1] == (acc == 32'h0))
      else $error("record form flags wrong");

   chk_ovf_only: assert property ( // RULE_11
      chk_calc && ctrl.ovf_en && !ctrl.record |=> $stable(cfz))
      else $error("overflow form changed condition field");

   chk_so_sticky: assert property ( // RULE_18
      chk_calc && ctrl.ovf_en && so |=> so)
      else $error("sticky flag cleared by hardware");

   chk_both_forms: assert property ( // RULE_12
      chk_calc && ctrl.ovf_en && ctrl.record
      |=> cfz[0] == so && cfz[3] == acc[31])
      else $error("combined form flags disagree");

   chk_bus_answer: assert property (
      !avs_waitrequest_o |=> avs_waitrequest_o [*2] or
      (avs_waitrequest_o ##1 !avs_waitrequest_o))
      else $error("waitrequest low for more than one cycle");

   cov_sat_signed: cover property (
      chk_calc && ctrl.variant == VAR_SAT_S && mac.ovf);
   cov_sat_unsigned: cover property (
      chk_calc && ctrl.variant == VAR_SAT_U && mac.ovf);
   cov_combined: cover property (
      chk_calc && ctrl.ovf_en && ctrl.record);
   cov_read_done: cover property (avs_read_i && !avs_waitrequest_o);

endmodule // chmu_top

`default_nettype wire

// ===== tb/chmu_core_model.sv
/*
 Core-side bus master model for the multiply-accumulate unit.
 Assumes the slave drops waitrequest within 40 cycles of a request.
*/
`timescale 1ns/100ps
`default_nettype none

module chmu_core_model (
   // Clock
   input  wire logic                 core_clk_i,
   // Avalon-MM master
   output var  chmu_pkg::chmu_addr_t avs_address_o,
   output logic                      avs_read_o,
   output logic                      avs_write_o,
   output var  chmu_pkg::chmu_word_t avs_writedata_o,
   output var  chmu_pkg::chmu_be_t   avs_byteenable_o,
   input  wire logic                 avs_waitrequest_i,
   // Status
   output logic                      hang_o
);
   import chmu_pkg::*;

   initial begin
      avs_address_o    = 8'h00;
      avs_read_o       = 1'b0;
      avs_write_o      = 1'b0;
      avs_writedata_o  = 32'h0000_0000;
      avs_byteenable_o = 4'h0;
      hang_o           = 1'b0;
   end

   // ----------------------------------------------------------------
   // One transfer, held until waitrequest is sampled low
   // ----------------------------------------------------------------
   task automatic xfer(input logic wr, input chmu_addr_t a,
                       input chmu_word_t d, input chmu_be_t be);
      int n;
      @(posedge core_clk_i);
      avs_address_o    <= a;
      avs_read_o       <= ~wr;
      avs_write_o      <= wr;
      avs_writedata_o  <= d;
      avs_byteenable_o <= be;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (avs_waitrequest_i !== 1'b0 && n < 40);
      if (avs_waitrequest_i !== 1'b0) begin
         hang_o <= 1'b1;
      end
      avs_read_o      <= 1'b0;
      avs_write_o     <= 1'b0;
      // Released address and write data show the inverse so stale values never match
      avs_address_o   <= ~a;
      avs_writedata_o <= ~d;
   endtask
endmodule // chmu_core_model
`default_nettype wire

// ===== tb/testbench.sv
/*
 Self-checking bench for the multiply-accumulate unit.
 Assumes the core model drives the bus; reads are checked by a monitor.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import chmu_pkg::*;

   typedef struct packed {
      chmu_addr_t addr;
      chmu_word_t data;
   } chmu_note_t;

   logic       core_clk_i = 1'b0;
   logic       rst_i      = 1'b1;
   chmu_addr_t avs_address;
   logic       avs_read;
   logic       avs_write;
   chmu_word_t avs_writedata;
   chmu_be_t   avs_byteenable;
   chmu_word_t avs_readdata;
   logic       avs_waitrequest;
   logic       hang;
   chmu_note_t notes[$];
   chmu_note_t nt;
   int         n_errors     = 0;
   int         total_checks = 0;

   always #2.5 core_clk_i = ~core_clk_i;

   chmu_top dut (
      .core_clk_i        (core_clk_i),
      .rst_i             (rst_i),
      .avs_address_i     (avs_address),
      .avs_read_i        (avs_read),
      .avs_write_i       (avs_write),
      .avs_writedata_i   (avs_writedata),
      .avs_byteenable_i  (avs_byteenable),
      .avs_readdata_o    (avs_readdata),
      .avs_waitrequest_o (avs_waitrequest)
   );

   chmu_core_model core (
      .core_clk_i        (core_clk_i),
      .avs_address_o     (avs_address),
      .avs_read_o        (avs_read),
      .avs_write_o       (avs_write),
      .avs_writedata_o   (avs_writedata),
      .avs_byteenable_o  (avs_byteenable),
      .avs_waitrequest_i (avs_waitrequest),
      .hang_o            (hang)
   );

   // ----------------------------------------------------------------
   // Verdict and bus helpers
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wr(input chmu_addr_t a, input chmu_word_t d);
      core.xfer(1'b1, a, d, 4'hF);
   endtask

   task automatic rd(input chmu_addr_t a, input chmu_word_t e);
      notes.push_back('{a, e});
      core.xfer(1'b0, a, 32'h0000_0000, 4'hF);
   endtask

   // ----------------------------------------------------------------
   // Expected result of one operation, then the bus sequence
   // ----------------------------------------------------------------
   task automatic run_op(input chmu_ctrl_t c, input chmu_word_t sa,
                         input chmu_word_t sb, input chmu_word_t acc);
      logic signed [32:0] s_sum;
      logic [32:0]        u_sum;
      logic               sgn;
      logic               ovf;
      logic [1:0]         xr;
      chmu_cr_t           cr;
      chmu_cr_t           ecr;
      chmu_word_t         res;
      logic               eso;
      logic               eov;
      xr    = 2'($urandom);
      cr    = 4'($urandom);
      s_sum = $signed({acc[31], acc})
            + $signed(sa[15:0]) * $signed(sb[31:16]);
      u_sum = {1'b0, acc} + sa[15:0] * sb[31:16];
      sgn   = (c.variant == VAR_MOD_S) || (c.variant == VAR_SAT_S);
      ovf   = sgn ? (s_sum[32] != s_sum[31]) : u_sum[32];
      res   = sgn ? s_sum[31:0] : u_sum[31:0];
      if (ovf && c.variant == VAR_SAT_S) begin
         res = s_sum[32] ? SAT_S_MIN : SAT_S_MAX;
      end
      if (ovf && c.variant == VAR_SAT_U) begin
         res = SAT_U_MAX;
      end
      eso = xr[1];
      eov = xr[0];
      if (c.ovf_en) begin
         eov = ovf;
         eso = xr[1] | ovf;
      end
      ecr = c.record ? {res[31], !res[31] && res != 32'h0,
                        res == 32'h0, eso} : cr;
      wr(OFS_SRC_A, sa);
      wr(OFS_SRC_B, sb);
      wr(OFS_ACC, acc);
      wr(OFS_FPEX, {xr, 30'h0});
      wr(OFS_CFZ, {28'h0, cr});
      wr(OFS_CTRL, {27'h0, 1'b1, c});
      rd(OFS_ACC, res);
      rd(OFS_FPEX, {eso, eov, 30'h0});
      rd(OFS_CFZ, {28'h0, ecr});
      rd(OFS_CTRL, {28'h0, c});
   endtask

   // ----------------------------------------------------------------
   // Read monitor: each completed read takes the oldest note
   // ----------------------------------------------------------------
   always @(posedge core_clk_i) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (notes.size() == 0) begin
            n_errors++;
            $display("unexpected readdata: no note, seen %h", avs_readdata);
         end else begin
            nt = notes.pop_front();
            total_checks++;
            if (avs_readdata !== nt.data) begin
               n_errors++;
               $display("unexpected readdata at %h: expected %h seen %h",
                        nt.addr, nt.data, avs_readdata);
            end
         end
      end
   end

   always @(posedge hang) begin
      n_errors++;
      final_report();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   chmu_word_t  d_acc[4] = '{32'h7FFF_FFFF, 32'h8000_0000,
                             32'hFFFF_FFFF, 32'h0000_0000};
   logic [15:0] d_a[4]   = '{16'h0001, 16'hFFFF, 16'h0001, 16'h0000};
   logic [15:0] d_b[4]   = '{16'h0001, 16'h0001, 16'h0001, 16'h8000};

   initial begin
      chmu_word_t sa;
      chmu_word_t sb;
      chmu_word_t acc;
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
      void'($urandom(19));
      repeat (2) @(posedge core_clk_i);
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), 32'h0000_0000);
      end
      wr(8'h18, 32'hFFFF_FFFF);
      rd(8'h18, 32'h0000_0000);
      wr(OFS_SRC_A, 32'h1122_3344);
      core.xfer(1'b1, OFS_SRC_A, 32'hAABB_CCDD, 4'h5);
      rd(OFS_SRC_A, 32'h11BB_33DD);
      for (int v = 0; v < 16; v++) begin
         for (int k = 0; k < 7; k++) begin
            sa  = $urandom;
            sb  = $urandom;
            acc = $urandom;
            if (k < 4) begin
               sa  = {sa[31:16], d_a[k]};
               sb  = {d_b[k], sb[15:0]};
               acc = d_acc[k];
            end
            run_op(chmu_ctrl_t'(v), sa, sb, acc);
         end
      end
      wr(OFS_ACC, 32'h1234_5678);
      @(posedge core_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rd(OFS_ACC, 32'h0000_0000);
      repeat (3) @(posedge core_clk_i);
      if (notes.size() != 0) begin
         n_errors++;
         $display("unexpected pending reads: expected 0 seen %0d",
                  notes.size());
      end
      final_report();
   end
endmodule // testbench
`default_nettype wire
